/* File: lpmc_params.svh */
// constants for the low-power mode controller
`ifndef LPMC_PARAMS_SVH
`define LPMC_PARAMS_SVH
// register offsets
`define LPMC_ADDR_CTRL   8'h00
`define LPMC_ADDR_STATUS 8'h04
`define LPMC_ADDR_MASK   8'h08
`define LPMC_ADDR_STATE  8'h0C
// control fields
`define LPMC_CTRL_MODE_LO 0
`define LPMC_CTRL_MODE_HI 1
`define LPMC_CTRL_LPR     2
`define LPMC_CTRL_UDRV    3
`define LPMC_CTRL_RST     4'h0
// number of wake lines: 16 event, detector, 4 rtc, usb, eth, timer, cec
`define LPMC_NUM_WAKE     25
// reset hold cycles after standby exit
`define LPMC_RST_CYC      4'h8
`endif

/* File: lpmc_pkg.sv */
// types for the low-power mode controller
package lpmc_pkg;
   typedef enum logic [1:0] {
      LPMC_RUN   = 2'b00,
      LPMC_SLEEP = 2'b01,
      LPMC_STOP  = 2'b10,
      LPMC_STBY  = 2'b11
   } lpmc_state_e;
   typedef struct packed {
      logic cpu_clk_en;
      logic core_clk_en;
      logic pll_en;
      logic irc_en;
      logic xtal_en;
      logic reg_on;
      logic use_lpr;
      logic underdrive;
   } lpmc_pwr_s;
endpackage

/* File: lpmc_top.sv */
// low-power mode controller: sleep, stop and standby sequencing
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`include "lpmc_params.svh"
module lpmc_top
   import lpmc_pkg::*;
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        reset,
   // register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   // processor side
   input  wire logic        wfi_req,
   input  wire logic        periph_irq,
   // wake sources (asynchronous)
   input  wire logic [15:0] external_event_lines,
   input  wire logic        supply_level_detector,
   input  wire logic [3:0]  rtc_wake,
   input  wire logic        usb_wake,
   input  wire logic        eth_wake,
   input  wire logic        low_power_timer,
   input  wire logic        cec_rx_wake,
   // power and clock controls, reset request and interrupt
   output lpmc_pwr_s        pwr,
   output logic             sys_reset_req,
   output logic             irq
);
//----------------------------------------------------------------------
// wake synchronisers
//----------------------------------------------------------------------
   logic [`LPMC_NUM_WAKE-1:0] wk_raw, wk_m_q, wk_s_q;
   assign wk_raw = {cec_rx_wake, low_power_timer, eth_wake, usb_wake,
                    rtc_wake, supply_level_detector, external_event_lines};
   // first stage read only by second stage
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         wk_m_q <= '0;
         wk_s_q <= '0;
      end else begin
         wk_m_q <= wk_raw;
         wk_s_q <= wk_m_q;
      end
   end
   logic ext_wake, cec_wake;
   assign ext_wake = |wk_s_q[`LPMC_NUM_WAKE-2:0];
   assign cec_wake = wk_s_q[`LPMC_NUM_WAKE-1];
//----------------------------------------------------------------------
// registers and state machine
//----------------------------------------------------------------------
   logic [3:0]  ctrl_q, ctrl_d;
   logic [2:0]  sts_q, sts_d, mask_q, mask_d;
   lpmc_state_e st_q, st_d;
   logic [3:0]  rcnt_q, rcnt_d;
   logic [31:0] rdata_q, rdata_d;
   logic        wr_ctrl, wr_sts, wr_mask;
   assign wr_ctrl = reg_wr && reg_addr == `LPMC_ADDR_CTRL;
   assign wr_sts  = reg_wr && reg_addr == `LPMC_ADDR_STATUS;
   assign wr_mask = reg_wr && reg_addr == `LPMC_ADDR_MASK;
   // next state: mode entry on wfi, exit on wake
   always_comb begin
      st_d   = st_q;
      rcnt_d = (rcnt_q != 4'h0) ? rcnt_q - 4'h1 : 4'h0;
      ctrl_d = wr_ctrl ? reg_wdata[3:0] : ctrl_q;
      mask_d = wr_mask ? reg_wdata[2:0] : mask_q;
      sts_d  = wr_sts ? (sts_q & ~reg_wdata[2:0]) : sts_q;
      case (st_q)
         LPMC_RUN: begin
            if (wfi_req) begin
               case (ctrl_q[`LPMC_CTRL_MODE_HI:`LPMC_CTRL_MODE_LO])
                  2'b01:   st_d = LPMC_SLEEP;
                  2'b10:   st_d = LPMC_STOP;
                  2'b11:   st_d = LPMC_STBY;
                  default: st_d = LPMC_RUN;
               endcase
            end
         end
         LPMC_SLEEP: begin
            if (periph_irq || ext_wake) begin
               st_d     = LPMC_RUN;
               sts_d[0] = 1'b1; // set wins over clear
            end
         end
         LPMC_STOP: begin
            // registers untouched; resume in place
            if (ext_wake || cec_wake) begin
               st_d     = LPMC_RUN;
               sts_d[1] = 1'b1;
            end
         end
         LPMC_STBY: begin
            // core state lost, so leave via reset
            if (ext_wake) begin
               st_d     = LPMC_RUN;
               rcnt_d   = `LPMC_RST_CYC;
               sts_d[2] = 1'b1;
               ctrl_d   = `LPMC_CTRL_RST;
            end
         end
         default: st_d = LPMC_RUN;
      endcase
      rdata_d = 32'h0000_0000;
      if (reg_rd) begin
         case (reg_addr)
            `LPMC_ADDR_CTRL:   rdata_d = {28'h0, ctrl_q};
            `LPMC_ADDR_STATUS: rdata_d = {29'h0, sts_q};
            `LPMC_ADDR_MASK:   rdata_d = {29'h0, mask_q};
            `LPMC_ADDR_STATE:  rdata_d = {30'h0, st_q};
            default:           rdata_d = 32'h0000_0000;
         endcase
      end
   end
   // registering
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         st_q    <= LPMC_RUN;
         ctrl_q  <= `LPMC_CTRL_RST;
         sts_q   <= 3'h0;
         mask_q  <= 3'h0;
         rcnt_q  <= 4'h0;
         rdata_q <= 32'h0000_0000;
      end else begin
         st_q    <= st_d;
         ctrl_q  <= ctrl_d;
         sts_q   <= sts_d;
         mask_q  <= mask_d;
         rcnt_q  <= rcnt_d;
         rdata_q <= rdata_d;
      end
   end
//----------------------------------------------------------------------
// outputs
//----------------------------------------------------------------------
   // power controls decoded from state
   always_comb begin
      pwr.cpu_clk_en  = (st_q == LPMC_RUN);
      pwr.core_clk_en = (st_q == LPMC_RUN) || (st_q == LPMC_SLEEP);
      pwr.pll_en      = pwr.core_clk_en;
      pwr.irc_en      = pwr.core_clk_en;
      pwr.xtal_en     = pwr.core_clk_en;
      pwr.reg_on      = (st_q != LPMC_STBY);
      // regulator choice only applies in stop; normal otherwise
      pwr.use_lpr     = (st_q == LPMC_STOP) && ctrl_q[`LPMC_CTRL_LPR];
      pwr.underdrive  = (st_q == LPMC_STOP) && ctrl_q[`LPMC_CTRL_UDRV];
   end
   assign sys_reset_req = (rcnt_q != 4'h0);
   assign irq           = |(sts_q & mask_q);
   assign reg_rdata     = rdata_q;
//----------------------------------------------------------------------
// checks
//----------------------------------------------------------------------
   // sleep: processor clock off, everything else still clocked
   sleep_clk_a: assert property (@(posedge mclk) disable iff (reset)
      st_q == LPMC_SLEEP |-> !pwr.cpu_clk_en && pwr.core_clk_en
         && pwr.pll_en && pwr.reg_on)
      else $error("sleep clocks wrong");

   // run: processor clocked and core powered
   run_clk_a: assert property (@(posedge mclk) disable iff (reset)
      st_q == LPMC_RUN |-> pwr.cpu_clk_en && pwr.core_clk_en
         && pwr.reg_on)
      else $error("run clocks wrong");

   // sleep: a peripheral interrupt returns to run next cycle
   sleep_wake_a: assert property (@(posedge mclk) disable iff (reset)
      st_q == LPMC_SLEEP && periph_irq |=> st_q == LPMC_RUN && sts_q[0])
      else $error("sleep did not wake");

   // sleep: a synced event line wakes too
   sleep_evt_a: assert property (@(posedge mclk) disable iff (reset)
      st_q == LPMC_SLEEP && ext_wake |=> st_q == LPMC_RUN)
      else $error("sleep ignored event");

   // stop: software-visible setup survives the stay
   stop_keep_a: assert property (@(posedge mclk) disable iff (reset)
      st_q == LPMC_STOP && !wr_ctrl |=> ctrl_q == $past(ctrl_q))
      else $error("stop lost state");

   // stop: mask is kept as well
   stop_mask_a: assert property (@(posedge mclk) disable iff (reset)
      st_q == LPMC_STOP && !wr_mask |=> mask_q == $past(mask_q))
      else $error("stop lost mask");

   // stop: every core clock gated
   stop_gate_a: assert property (@(posedge mclk) disable iff (reset)
      st_q == LPMC_STOP |-> !pwr.core_clk_en && !pwr.cpu_clk_en)
      else $error("stop clocks running");

   // stop: PLL and both fast oscillators off
   stop_osc_a: assert property (@(posedge mclk) disable iff (reset)
      st_q == LPMC_STOP |-> !pwr.pll_en && !pwr.irc_en && !pwr.xtal_en)
      else $error("stop oscillators running");

   // stop: regulator choice follows the control bit
   stop_reg_a: assert property (@(posedge mclk) disable iff (reset)
      st_q == LPMC_STOP |-> pwr.use_lpr == ctrl_q[`LPMC_CTRL_LPR]
         && pwr.reg_on)
      else $error("stop regulator wrong");

   // stop: under-drive only when asked for; normal is default
   stop_normal_a: assert property (@(posedge mclk) disable iff (reset)
      st_q == LPMC_STOP |-> pwr.underdrive == ctrl_q[`LPMC_CTRL_UDRV])
      else $error("stop drive setting wrong");

   // outside stop the regulator stays in normal form
   run_normal_a: assert property (@(posedge mclk) disable iff (reset)
      st_q != LPMC_STOP |-> !pwr.underdrive && !pwr.use_lpr)
      else $error("underdrive outside stop");

   // stop: any synced event line leaves stop and flags it
   stop_wake_a: assert property (@(posedge mclk) disable iff (reset)
      st_q == LPMC_STOP && ext_wake |=> st_q == LPMC_RUN && sts_q[1])
      else $error("stop did not wake");

   // stop: receiver wake on its own line also leaves stop
   stop_cec_a: assert property (@(posedge mclk) disable iff (reset)
      st_q == LPMC_STOP && cec_wake |=> st_q == LPMC_RUN && sts_q[1])
      else $error("receiver wake missed");

   // standby: regulator off, core domain unpowered
   stby_off_a: assert property (@(posedge mclk) disable iff (reset)
      st_q == LPMC_STBY |-> !pwr.reg_on && !pwr.core_clk_en)
      else $error("standby powered");

   // regulator only ever drops in standby
   reg_on_a: assert property (@(posedge mclk) disable iff (reset)
      st_q != LPMC_STBY |-> pwr.reg_on)
      else $error("regulator off outside standby");

   // standby: PLL and both fast oscillators off
   stby_osc_a: assert property (@(posedge mclk) disable iff (reset)
      st_q == LPMC_STBY |-> !pwr.pll_en && !pwr.irc_en && !pwr.xtal_en)
      else $error("standby oscillators running");

   // standby exit goes through a full reset pulse
   stby_reset_a: assert property (@(posedge mclk) disable iff (reset)
      st_q == LPMC_STBY && ext_wake |=> sys_reset_req [*8]
         ##1 !sys_reset_req)
      else $error("standby exit without reset");

   // setup is dropped on standby exit since core state was lost
   stby_clr_a: assert property (@(posedge mclk) disable iff (reset)
      st_q == LPMC_STBY && ext_wake |=> ctrl_q == `LPMC_CTRL_RST)
      else $error("standby exit kept setup");

   // main scenarios
   sleep_c: cover property (@(posedge mclk) disable iff (reset)
      st_q == LPMC_SLEEP ##[1:20] st_q == LPMC_RUN);
   stop_c: cover property (@(posedge mclk) disable iff (reset)
      st_q == LPMC_STOP ##[1:20] st_q == LPMC_RUN);
   stop_ud_c: cover property (@(posedge mclk) disable iff (reset)
      st_q == LPMC_STOP && pwr.underdrive && pwr.use_lpr);
   cec_c: cover property (@(posedge mclk) disable iff (reset)
      st_q == LPMC_STOP && cec_wake ##1 st_q == LPMC_RUN);
   stby_c: cover property (@(posedge mclk) disable iff (reset)
      st_q == LPMC_STBY ##1 sys_reset_req);
endmodule

/* File: lpmc_wake_src.sv */
// wake-source model: pulses one chosen wake line for a few cycles
`timescale 1ns/10ps
module lpmc_wake_src (
   // clock, reset and command
   input  wire logic        mclk,
   input  wire logic        reset,
   input  wire logic        fire,
   input  wire logic [4:0]  src,
   // wake lines
   output logic      [15:0] external_event_lines,
   output logic             supply_level_detector,
   output logic      [3:0]  rtc_wake,
   output logic             usb_wake,
   output logic             eth_wake,
   output logic             low_power_timer,
   output logic             cec_rx_wake
);
   logic [24:0] hold_q;
   logic [2:0]  cnt_q;
   // level held 7 cycles so the 2-flop sync surely sees it, then idles low
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         hold_q <= 25'h0;
         cnt_q  <= 3'h0;
      end else if (fire) begin
         hold_q <= 25'h1 << src;
         cnt_q  <= 3'h6;
      end else if (cnt_q != 3'h0) begin
         cnt_q  <= cnt_q - 3'h1;
      end else begin
         hold_q <= 25'h0;
      end
   end
   assign {cec_rx_wake, low_power_timer, eth_wake, usb_wake, rtc_wake,
           supply_level_detector, external_event_lines} = hold_q;
endmodule

/* File: low_power_mode_control_tb.sv */
// testbench: sleep, stop and standby entry and wake
`timescale 1ns/10ps
module low_power_mode_control_tb;
   import lpmc_pkg::*;
   logic mclk, reset, reg_wr, reg_rd, wfi_req, periph_irq, fire, sys_reset_req;
   logic irq, slv, usb, eth, lpt, cec;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, d;
   logic [15:0] ext;
   logic [3:0]  rtc;
   logic [4:0]  src;
   lpmc_pwr_s   pwr;
   int          mismatches, compares, cyc, n;
   lpmc_top i_lpmc_top (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .wfi_req(wfi_req), .periph_irq(periph_irq),
      .external_event_lines(ext), .supply_level_detector(slv),
      .rtc_wake(rtc), .usb_wake(usb), .eth_wake(eth), .low_power_timer(lpt),
      .cec_rx_wake(cec), .pwr(pwr), .sys_reset_req(sys_reset_req), .irq(irq));
   lpmc_wake_src i_lpmc_wake_src (.mclk(mclk), .reset(reset), .fire(fire),
      .src(src), .external_event_lines(ext), .supply_level_detector(slv),
      .rtc_wake(rtc), .usb_wake(usb), .eth_wake(eth), .low_power_timer(lpt),
      .cec_rx_wake(cec));
   //----------------------------------------------------------------
   // bus and check tasks
   //----------------------------------------------------------------
   task automatic chk(string n, logic [31:0] got, logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", n, exp, got);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] v);
      @(posedge mclk) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v; end
      @(posedge mclk) reg_wr <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a);
      @(posedge mclk) begin reg_rd <= 1'b1; reg_addr <= a; end
      @(posedge mclk) reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // wfi pulse, then let the state change land before looking
   task automatic enter(logic [31:0] ctrl);
      wr(8'h00, ctrl);
      @(posedge mclk) wfi_req <= 1'b1;
      @(posedge mclk) wfi_req <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
   endtask
   task automatic wake(int s);
      @(posedge mclk) begin fire <= 1'b1; src <= 5'(s); end
      @(posedge mclk) fire <= 1'b0;
      repeat (8) @(posedge mclk);
      #1;
   endtask
   task test_done;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // clock and hang guard
   initial begin mclk = 1'b0; forever #5 mclk = ~mclk; end
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 5000) begin mismatches++; test_done; end
   end
   //----------------------------------------------------------------
   // main sequence
   //----------------------------------------------------------------
   initial begin
      {reset, reg_wr, reg_rd, wfi_req, periph_irq, fire} = 6'b100000;
      reg_addr = 8'h00; reg_wdata = 32'h0; src = 5'h0;
      repeat (5) @(posedge mclk);
      reset <= 1'b0;
      chk("pwr_rst", 32'(pwr), 32'hFC);
      rd(8'h40); chk("unmapped", d, 32'h0);
      enter(32'h0); chk("pwr_mode_none", 32'(pwr), 32'hFC);
      wr(8'h08, 32'h2);
      // sleep: only processor clock stops, irq wakes
      enter(32'h1); chk("pwr_sleep", 32'(pwr), 32'h7C);
      rd(8'h0C); chk("state_sleep", d, 32'h1);
      @(posedge mclk) periph_irq <= 1'b1;
      @(posedge mclk) periph_irq <= 1'b0;
      repeat (3) @(posedge mclk);
      #1 chk("pwr_sleep_wake", 32'(pwr), 32'hFC);
      chk("irq_masked", 32'(irq), 32'h0);
      rd(8'h04); chk("sts_sleep", d, 32'h1);
      wr(8'h04, 32'h7);
      // stop: every wake source, every regulator setting
      for (int i = 0; i < 25; i++) begin
         enter(32'h2 | ((i & 3) << 2));
         // use_lpr sits above underdrive in the struct
         chk("pwr_stop", 32'(pwr),
             32'h4 | ((i & 1) << 1) | ((i >> 1) & 1));
         wake(i);
         chk("pwr_stop_wake", 32'(pwr), 32'hFC);
         chk("irq_stop", 32'(irq), 32'h1);
         rd(8'h00); chk("ctrl_kept", d, 32'h2 | ((i & 3) << 2));
         wr(8'h04, 32'h2);
         #1 chk("irq_clr", 32'(irq), 32'h0);
      end
      // standby: everything off, wake restarts through reset
      enter(32'h3); chk("pwr_stby", 32'(pwr), 32'h00);
      @(posedge mclk) begin fire <= 1'b1; src <= 5'h3; end
      @(posedge mclk) fire <= 1'b0;
      for (int k = 0; k < 20 && sys_reset_req !== 1'b1; k++) begin
         @(posedge mclk);
         #1;
      end
      chk("rst_req", 32'(sys_reset_req), 32'h1);
      n = 0;
      while (sys_reset_req === 1'b1 && n < 20) begin
         @(posedge mclk);
         #1 n++;
      end
      chk("rst_len", n, 32'd8);
      repeat (10) @(posedge mclk);
      rd(8'h00); chk("ctrl_clr", d, 32'h0);
      rd(8'h04); chk("sts_stby", d, 32'h4);
      test_done;
   end
endmodule
